// [pkg/tmirq_pkg.sv]
// Package for the timer interrupt flag block: register map, field positions and modes.
`default_nettype none
package tmirq_pkg;
   // -------------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------------
   localparam logic [11:0] ADDR_ENABLE_MASK = 12'h000;
   localparam logic [11:0] ADDR_FLAG_STATUS = 12'h004;
   localparam logic [11:0] ADDR_MODE_CTRL   = 12'h008;
   localparam logic [7:0]  MASK_RESET       = 8'h00;
   localparam logic [7:0]  FLAG_RESET       = 8'h00;
   localparam logic [3:0]  MODE_RESET       = 4'h0;
   localparam logic [7:0]  FLAG_IMPL        = 8'hE8;
   localparam logic [31:0] DATA_ZERO        = 32'h0000_0000;

   // -------------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------------
   localparam int BIT_OVF  = 7;
   localparam int BIT_CMPA = 6;
   localparam int BIT_CMPB = 5;
   localparam int BIT_CAPT = 3;

   // -------------------------------------------------------------------------
   // Waveform mode codes
   // -------------------------------------------------------------------------
   localparam logic [3:0] MODE_NORMAL    = 4'h0;
   localparam logic [3:0] MODE_CTC_CMPA  = 4'h4;
   localparam logic [3:0] MODE_PFC_CAPT  = 4'h8;
   localparam logic [3:0] MODE_PFC_CMPA  = 4'h9;
   localparam logic [3:0] MODE_PC_CAPT   = 4'hA;
   localparam logic [3:0] MODE_PC_CMPA   = 4'hB;
   localparam logic [3:0] MODE_CTC_CAPT  = 4'hC;
   localparam logic [3:0] MODE_FAST_CAPT = 4'hE;

   // Timer events from the counter datapath.
   typedef struct packed {
      logic overflow;
      logic at_top;
      logic at_bottom;
      logic match_a;
      logic match_b;
      logic capture_edge;
      logic force_a;
      logic force_b;
   } tmirq_event_t;

   // Vector acknowledges from the core.
   typedef struct packed {
      logic ovf;
      logic cmpa;
      logic cmpb;
      logic capt;
   } tmirq_ack_t;

   // Whole module state.
   typedef struct packed {
      logic [7:0]   mask;
      logic [7:0]   flags;
      logic [3:0]   mode;
      logic         cap_meta;
      logic         cap_sync;
      logic         cap_prev;
      logic [31:0]  prdata;
   } tmirq_state_t;
endpackage : tmirq_pkg
`default_nettype wire

// [core/tmirq_flags.sv]
// Interrupt enable and flag logic for a 16-bit timer with APB register access.
//
// Functional notes
// - Overflow request needs enable bit 7, global enable and overflow flag.
// - Compare A request needs enable bit 6, global enable and its flag.
// - Compare B request needs enable bit 5, global enable and its flag.
// - Capture request needs enable bit 3, global enable and capture flag.
// - Normal and clear-on-compare modes set overflow flag on counter overflow.
// - Overflow flag clears on vector acknowledge or software write of one.
// - Compare A flag sets in the cycle after a counter match.
// - A forced compare A strobe never sets compare A flag.
// - Compare A flag clears on vector acknowledge or write of one.
// - Compare B flag sets in the cycle after a counter match.
// - A forced compare B strobe never sets compare B flag.
// - Compare B flag clears on vector acknowledge or write of one.
// - Capture flag sets on a capture pin event, except while capture register is top.
// - When capture register is top, capture flag sets on reaching top.
// - Capture flag clears on vector acknowledge or write of one.
// - Capture pin is ignored while capture register serves as top.
// - Forced compare strobes raise no interrupt and clear nothing.
`default_nettype none
module tmirq_flags (
   input  wire logic                   core_clk_i,
   input  wire logic                   nrst_i,
   input  wire logic                   clk_en_i,
   input  wire logic                   psel_i,
   input  wire logic                   penable_i,
   input  wire logic                   pwrite_i,
   input  wire logic [11:0]            paddr_i,
   input  wire logic [31:0]            pwdata_i,
   input  wire logic [3:0]             pstrb_i,
   output logic      [31:0]            prdata_o,
   output logic                        pready_o,
   output logic                        pslverr_o,
   input  wire tmirq_pkg::tmirq_event_t event_i,
   input  wire logic                   capture_input_pin_i,
   input  wire tmirq_pkg::tmirq_ack_t  ack_i,
   input  wire logic                   global_irq_enable_i,
   output tmirq_pkg::tmirq_ack_t       irq_req_o,
   output logic [3:0]                  waveform_mode_select_o,
   output logic                        irq_o
);
   // ------------------------------------------------------------------------
   // Mode decoding
   // ------------------------------------------------------------------------
   function automatic logic capt_is_top(input logic [3:0] m);
      capt_is_top = (m == tmirq_pkg::MODE_PFC_CAPT) || (m == tmirq_pkg::MODE_PC_CAPT) ||
                    (m == tmirq_pkg::MODE_CTC_CAPT) || (m == tmirq_pkg::MODE_FAST_CAPT);
   endfunction : capt_is_top

   function automatic logic ovf_at_bottom(input logic [3:0] m);
      ovf_at_bottom = (m >= tmirq_pkg::MODE_PFC_CAPT) && (m <= tmirq_pkg::MODE_PC_CMPA);
   endfunction : ovf_at_bottom

   function automatic logic ovf_on_max(input logic [3:0] m);
      ovf_on_max = (m == tmirq_pkg::MODE_NORMAL) || (m == tmirq_pkg::MODE_CTC_CMPA) ||
                   (m == tmirq_pkg::MODE_CTC_CAPT);
   endfunction : ovf_on_max

   tmirq_pkg::tmirq_state_t st;
   tmirq_pkg::tmirq_state_t next_st;

   logic        wr_en;
   logic        rd_en;
   logic [7:0]  set_vec;
   logic [7:0]  clr_vec;
   logic [7:0]  req_vec;
   logic        cap_event;

   // ------------------------------------------------------------------------
   // Bus decode and flag update
   // ------------------------------------------------------------------------
   // The slave answers in the first access cycle, so pready is held high.
   assign wr_en = psel_i && penable_i && pwrite_i && pstrb_i[0];
   // Read data is captured in the setup cycle, so it stands through the access cycle.
   assign rd_en = psel_i && !penable_i && !pwrite_i;

   // Edge selection lives in the capture datapath; here a level change is the event.
   // The first stage of the pin synchroniser feeds nothing else.
   assign cap_event = (st.cap_sync != st.cap_prev) && event_i.capture_edge
                      && !capt_is_top(st.mode);

   always_comb begin
      set_vec = 8'h00;
      clr_vec = 8'h00;
      set_vec[tmirq_pkg::BIT_OVF]  = (ovf_on_max(st.mode) && event_i.overflow)
         || (ovf_at_bottom(st.mode) && event_i.at_bottom)
         || (!ovf_on_max(st.mode) && !ovf_at_bottom(st.mode) && event_i.at_top);
      // Match strobes are registered here, so the flag shows one cycle later.
      set_vec[tmirq_pkg::BIT_CMPA] = event_i.match_a && !event_i.force_a;
      set_vec[tmirq_pkg::BIT_CMPB] = event_i.match_b && !event_i.force_b;
      set_vec[tmirq_pkg::BIT_CAPT] = cap_event
         || (capt_is_top(st.mode) && event_i.at_top);
      clr_vec[tmirq_pkg::BIT_OVF]  = ack_i.ovf;
      clr_vec[tmirq_pkg::BIT_CMPA] = ack_i.cmpa;
      clr_vec[tmirq_pkg::BIT_CMPB] = ack_i.cmpb;
      clr_vec[tmirq_pkg::BIT_CAPT] = ack_i.capt;
      if (wr_en && (paddr_i == tmirq_pkg::ADDR_FLAG_STATUS)) begin
         clr_vec = clr_vec | pwdata_i[7:0];
      end
   end

   always_comb begin
      next_st          = st;
      next_st.cap_meta = capture_input_pin_i;
      next_st.cap_sync = st.cap_meta;
      next_st.cap_prev = st.cap_sync;
      // A set arriving with a clear wins, so no event is lost.
      next_st.flags    = ((st.flags & ~clr_vec) | set_vec) & tmirq_pkg::FLAG_IMPL;
      if (wr_en) begin
         if (paddr_i == tmirq_pkg::ADDR_ENABLE_MASK) begin
            next_st.mask = pwdata_i[7:0] & tmirq_pkg::FLAG_IMPL;
         end else if (paddr_i == tmirq_pkg::ADDR_MODE_CTRL) begin
            next_st.mode = pwdata_i[3:0];
         end
      end
      next_st.prdata = tmirq_pkg::DATA_ZERO;
      if (rd_en) begin
         if (paddr_i == tmirq_pkg::ADDR_ENABLE_MASK) begin
            next_st.prdata[7:0] = st.mask;
         end else if (paddr_i == tmirq_pkg::ADDR_FLAG_STATUS) begin
            next_st.prdata[7:0] = st.flags;
         end else if (paddr_i == tmirq_pkg::ADDR_MODE_CTRL) begin
            next_st.prdata[3:0] = st.mode;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         st.mask     <= tmirq_pkg::MASK_RESET;
         st.flags    <= tmirq_pkg::FLAG_RESET;
         st.mode     <= tmirq_pkg::MODE_RESET;
         st.cap_meta <= 1'b0;
         st.cap_sync <= 1'b0;
         st.cap_prev <= 1'b0;
         st.prdata   <= tmirq_pkg::DATA_ZERO;
      end else if (clk_en_i) begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------------------
   // Requests and bus answer
   // ------------------------------------------------------------------------
   assign req_vec = st.flags & st.mask & {8{global_irq_enable_i}};
   assign irq_req_o.ovf  = req_vec[tmirq_pkg::BIT_OVF];
   assign irq_req_o.cmpa = req_vec[tmirq_pkg::BIT_CMPA];
   assign irq_req_o.cmpb = req_vec[tmirq_pkg::BIT_CMPB];
   assign irq_req_o.capt = req_vec[tmirq_pkg::BIT_CAPT];
   assign irq_o = |(st.flags & st.mask);
   assign waveform_mode_select_o = st.mode;
   assign prdata_o  = st.prdata;
   // No wait states: a frozen clock enable drops writes, so software keeps it high.
   assign pready_o  = 1'b1;
   assign pslverr_o = 1'b0;

   // ------------------------------------------------------------------------
   // Checks on requests
   // ------------------------------------------------------------------------
   default clocking chk_cb @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);

   localparam int OVF  = tmirq_pkg::BIT_OVF;
   localparam int CMPA = tmirq_pkg::BIT_CMPA;
   localparam int CMPB = tmirq_pkg::BIT_CMPB;
   localparam int CAPT = tmirq_pkg::BIT_CAPT;

   logic flag_wr;
   assign flag_wr = wr_en && (paddr_i == tmirq_pkg::ADDR_FLAG_STATUS);

   a_ovf_request: assert property (
      irq_req_o.ovf == (st.flags[OVF] && st.mask[OVF] && global_irq_enable_i))
      else $error("Overflow request mismatch.");

   a_cmpa_request: assert property (
      irq_req_o.cmpa == (st.flags[CMPA] && st.mask[CMPA] && global_irq_enable_i))
      else $error("Compare A request mismatch.");

   a_cmpb_request: assert property (
      irq_req_o.cmpb == (st.flags[CMPB] && st.mask[CMPB] && global_irq_enable_i))
      else $error("Compare B request mismatch.");

   a_capt_request: assert property (
      irq_req_o.capt == (st.flags[CAPT] && st.mask[CAPT] && global_irq_enable_i))
      else $error("Capture request mismatch.");

   a_ovf_global: assert property (
      !global_irq_enable_i |-> !irq_req_o.ovf)
      else $error("Overflow request without global enable.");

   a_cmpa_global: assert property (
      !global_irq_enable_i |-> !irq_req_o.cmpa)
      else $error("Compare A request without global enable.");

   a_cmpb_global: assert property (
      !global_irq_enable_i |-> !irq_req_o.cmpb)
      else $error("Compare B request without global enable.");

   a_capt_global: assert property (
      !global_irq_enable_i |-> !irq_req_o.capt)
      else $error("Capture request without global enable.");

   a_ovf_masked: assert property (
      !st.mask[OVF] |-> !irq_req_o.ovf)
      else $error("Masked overflow request.");

   a_cmpa_masked: assert property (
      !st.mask[CMPA] |-> !irq_req_o.cmpa)
      else $error("Masked compare A request.");

   a_cmpb_masked: assert property (
      !st.mask[CMPB] |-> !irq_req_o.cmpb)
      else $error("Masked compare B request.");

   a_capt_masked: assert property (
      !st.mask[CAPT] |-> !irq_req_o.capt)
      else $error("Masked capture request.");

   a_irq_level: assert property (
      irq_o == |(st.flags & st.mask))
      else $error("Interrupt level mismatch.");

   // ------------------------------------------------------------------------
   // Checks on the overflow flag
   // ------------------------------------------------------------------------
   a_ovf_normal: assert property (
      clk_en_i && (st.mode == tmirq_pkg::MODE_NORMAL) && event_i.overflow |=> st.flags[OVF])
      else $error("Overflow flag not set in normal mode.");

   a_ovf_ctc: assert property (
      clk_en_i && (st.mode == tmirq_pkg::MODE_CTC_CMPA) && event_i.overflow |=> st.flags[OVF])
      else $error("Overflow flag not set in compare clear mode.");

   a_ovf_ctc_capt: assert property (
      clk_en_i && (st.mode == tmirq_pkg::MODE_CTC_CAPT) && event_i.overflow |=> st.flags[OVF])
      else $error("Overflow flag not set in capture clear mode.");

   a_ovf_bottom: assert property (
      clk_en_i && ovf_at_bottom(st.mode) && event_i.at_bottom |=> st.flags[OVF])
      else $error("Overflow flag not set at bottom.");

   a_ovf_top: assert property (
      clk_en_i && (st.mode == tmirq_pkg::MODE_FAST_CAPT) && event_i.at_top |=> st.flags[OVF])
      else $error("Overflow flag not set at top.");

   a_ovf_quiet: assert property (
      clk_en_i && !set_vec[OVF] && !st.flags[OVF] |=> !st.flags[OVF])
      else $error("Overflow flag set without event.");

   a_ovf_ack: assert property (
      clk_en_i && ack_i.ovf && !set_vec[OVF] |=> !st.flags[OVF])
      else $error("Overflow flag not cleared by acknowledge.");

   a_ovf_w1c: assert property (
      clk_en_i && flag_wr && pwdata_i[OVF] && !set_vec[OVF] |=> !st.flags[OVF])
      else $error("Overflow flag not cleared by write.");

   a_ovf_hold: assert property (
      clk_en_i && st.flags[OVF] && !clr_vec[OVF] |=> st.flags[OVF])
      else $error("Overflow flag lost.");

   // ------------------------------------------------------------------------
   // Checks on the compare flags
   // ------------------------------------------------------------------------
   a_cmpa_set: assert property (
      clk_en_i && event_i.match_a && !event_i.force_a |=> st.flags[CMPA])
      else $error("Compare A flag not set after match.");

   a_cmpa_force: assert property (
      clk_en_i && event_i.force_a && !st.flags[CMPA] |=> !st.flags[CMPA])
      else $error("Forced compare set flag A.");

   a_cmpa_quiet: assert property (
      clk_en_i && !event_i.match_a && !st.flags[CMPA] |=> !st.flags[CMPA])
      else $error("Compare A flag set without match.");

   a_cmpa_ack: assert property (
      clk_en_i && ack_i.cmpa && !set_vec[CMPA] |=> !st.flags[CMPA])
      else $error("Compare A flag not cleared by acknowledge.");

   a_cmpa_w1c: assert property (
      clk_en_i && flag_wr && pwdata_i[CMPA] && !set_vec[CMPA] |=> !st.flags[CMPA])
      else $error("Compare A flag not cleared by write.");

   a_cmpa_hold: assert property (
      clk_en_i && st.flags[CMPA] && !clr_vec[CMPA] |=> st.flags[CMPA])
      else $error("Compare A flag lost.");

   a_cmpb_set: assert property (
      clk_en_i && event_i.match_b && !event_i.force_b |=> st.flags[CMPB])
      else $error("Compare B flag not set after match.");

   a_cmpb_force: assert property (
      clk_en_i && event_i.force_b && !st.flags[CMPB] |=> !st.flags[CMPB])
      else $error("Forced compare set flag B.");

   a_cmpb_quiet: assert property (
      clk_en_i && !event_i.match_b && !st.flags[CMPB] |=> !st.flags[CMPB])
      else $error("Compare B flag set without match.");

   a_cmpb_ack: assert property (
      clk_en_i && ack_i.cmpb && !set_vec[CMPB] |=> !st.flags[CMPB])
      else $error("Compare B flag not cleared by acknowledge.");

   a_cmpb_w1c: assert property (
      clk_en_i && flag_wr && pwdata_i[CMPB] && !set_vec[CMPB] |=> !st.flags[CMPB])
      else $error("Compare B flag not cleared by write.");

   a_cmpb_hold: assert property (
      clk_en_i && st.flags[CMPB] && !clr_vec[CMPB] |=> st.flags[CMPB])
      else $error("Compare B flag lost.");

   a_force_a_quiet: assert property (
      clk_en_i && event_i.force_a && !st.flags[CMPA] |=> !irq_req_o.cmpa)
      else $error("Forced compare A raised a request.");

   a_force_b_quiet: assert property (
      clk_en_i && event_i.force_b && !st.flags[CMPB] |=> !irq_req_o.cmpb)
      else $error("Forced compare B raised a request.");

   // ------------------------------------------------------------------------
   // Checks on the capture flag
   // ------------------------------------------------------------------------
   a_capt_pin: assert property (
      clk_en_i && cap_event |=> st.flags[CAPT])
      else $error("Capture flag not set by pin event.");

   a_capt_top: assert property (
      clk_en_i && capt_is_top(st.mode) && event_i.at_top |=> st.flags[CAPT])
      else $error("Capture flag not set at top.");

   a_capt_pin_off: assert property (
      capt_is_top(st.mode) |-> !cap_event)
      else $error("Pin capture while capture value is top.");

   a_capt_quiet: assert property (
      clk_en_i && !set_vec[CAPT] && !st.flags[CAPT] |=> !st.flags[CAPT])
      else $error("Capture flag set without event.");

   a_capt_ack: assert property (
      clk_en_i && ack_i.capt && !set_vec[CAPT] |=> !st.flags[CAPT])
      else $error("Capture flag not cleared by acknowledge.");

   a_capt_w1c: assert property (
      clk_en_i && flag_wr && pwdata_i[CAPT] && !set_vec[CAPT] |=> !st.flags[CAPT])
      else $error("Capture flag not cleared by write.");

   a_capt_hold: assert property (
      clk_en_i && st.flags[CAPT] && !clr_vec[CAPT] |=> st.flags[CAPT])
      else $error("Capture flag lost.");

   // ------------------------------------------------------------------------
   // Checks on registers and bus
   // ------------------------------------------------------------------------
   a_flags_impl: assert property (
      (st.flags & ~tmirq_pkg::FLAG_IMPL) == 8'h00)
      else $error("Unimplemented flag bit set.");

   a_mask_impl: assert property (
      (st.mask & ~tmirq_pkg::FLAG_IMPL) == 8'h00)
      else $error("Unimplemented mask bit set.");

   a_mask_write: assert property (
      clk_en_i && wr_en && (paddr_i == tmirq_pkg::ADDR_ENABLE_MASK)
      |=> st.mask == ($past(pwdata_i[7:0]) & tmirq_pkg::FLAG_IMPL))
      else $error("Mask write lost.");

   a_mode_write: assert property (
      clk_en_i && wr_en && (paddr_i == tmirq_pkg::ADDR_MODE_CTRL)
      |=> st.mode == $past(pwdata_i[3:0]))
      else $error("Mode write lost.");

   a_mode_output: assert property (
      waveform_mode_select_o == st.mode)
      else $error("Mode output mismatch.");

   a_read_idle: assert property (
      clk_en_i && !rd_en |=> (st.prdata == tmirq_pkg::DATA_ZERO))
      else $error("Read data not cleared.");

   a_ready_high: assert property (
      pready_o)
      else $error("Ready dropped.");

   a_no_slverr: assert property (
      !pslverr_o)
      else $error("Slave error raised.");

endmodule : tmirq_flags
`default_nettype wire

// [verif/tmirq_core_model.sv]
// Model of the core interrupt logic that acknowledges pending vectors.
`default_nettype none
module tmirq_core_model (
   input  wire logic                  clk_i,
   input  wire logic                  nrst_i,
   input  wire logic                  en_i,
   input  wire tmirq_pkg::tmirq_ack_t req_i,
   output tmirq_pkg::tmirq_ack_t      ack_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------------
   // Vector acknowledge
   // ------------------------------------------------------------------
   logic [1:0] cnt;
   logic [1:0] dly;
   // One source is taken per vector entry, so only the lowest request is acknowledged.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         ack_o <= '0;
         cnt   <= 2'h0;
         dly   <= 2'h0;
      end else if (ack_o != '0) begin
         ack_o <= '0;
         cnt   <= 2'h0;
         dly   <= 2'($urandom % 4);
      end else if (en_i && req_i != '0) begin
         if (cnt >= dly) begin
            ack_o <= tmirq_pkg::tmirq_ack_t'(req_i & (~req_i + 4'h1));
         end else begin
            cnt <= cnt + 2'h1;
         end
      end
   end
endmodule : tmirq_core_model
`default_nettype wire

// [verif/tmirq_flags_test.sv]
// Self-checking bench for the timer interrupt flag block.
`default_nettype none
module tmirq_flags_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic                    clk, nrst, psel, penable, pwrite, pin, glb, m_en, pready, pslverr, irq;
   logic [11:0]             paddr;
   logic [31:0]             pwdata, prdata, r;
   logic [3:0]              pstrb, wmode;
   logic [7:0]              mask, ef, c;
   tmirq_pkg::tmirq_event_t ev, v;
   tmirq_pkg::tmirq_ack_t   ack, req;
   int                      error_cnt, n_checks;
   tmirq_flags dut (.core_clk_i(clk), .nrst_i(nrst), .clk_en_i(1'b1), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .event_i(ev), .capture_input_pin_i(pin), .ack_i(ack), .global_irq_enable_i(glb),
      .irq_req_o(req), .waveform_mode_select_o(wmode), .irq_o(irq));
   tmirq_core_model core (.clk_i(clk), .nrst_i(nrst), .en_i(m_en), .req_i(req), .ack_o(ack));
   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, 4'hF};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         error_cnt++;
         stop_test();
      end
      r = prdata;
      {psel, penable} <= 2'b00;
   endtask : apb
   function automatic logic [3:0] req_f(input logic [7:0] f, input logic [7:0] m, input logic g);
      return {4{g}} & {f[7] & m[7], f[6] & m[6], f[5] & m[5], f[3] & m[3]};
   endfunction : req_f
   task automatic chk_all();
      apb(1'b0, tmirq_pkg::ADDR_FLAG_STATUS, 32'h0);
      chk(r & 32'h0000_00E8, {24'h0, ef});
      chk({28'h0, req}, {28'h0, req_f(ef, mask, glb)});
      chk({31'h0, irq}, {31'h0, |(ef & mask & 8'hE8)});
      chk({31'h0, pslverr}, 32'h0);
   endtask : chk_all
   task automatic pulse(input tmirq_pkg::tmirq_event_t e, input int len);
      @(posedge clk);
      ev <= e;
      repeat (len) @(posedge clk);
      ev <= '0;
   endtask : pulse
   task automatic clr_mode(input logic [3:0] md);
      apb(1'b1, tmirq_pkg::ADDR_FLAG_STATUS, 32'h0000_00FF);
      ef = 8'h00;
      apb(1'b1, tmirq_pkg::ADDR_MODE_CTRL, {28'h0, md});
      apb(1'b0, tmirq_pkg::ADDR_MODE_CTRL, 32'h0);
      chk(r & 32'h0000_000F, {28'h0, md});
      chk({28'h0, wmode}, {28'h0, md});
   endtask : clr_mode
   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      {nrst, psel, penable, pwrite, pin, glb, m_en, paddr, pwdata, pstrb} = '0;
      {ev, v, mask, ef, error_cnt, n_checks} = '0;
      void'($urandom(32'hF5C5));
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      apb(1'b0, tmirq_pkg::ADDR_ENABLE_MASK, 32'h0);
      chk(r, 32'h0);
      apb(1'b0, 12'h00C, 32'h0);
      chk(r, 32'h0);
      chk_all();
      $display("test reset done");
      for (int i = 0; i < 20; i++) begin
         mask = 8'($urandom);
         glb <= 1'($urandom);
         apb(1'b1, tmirq_pkg::ADDR_ENABLE_MASK, {24'h0, mask});
         apb(1'b0, tmirq_pkg::ADDR_ENABLE_MASK, 32'h0);
         chk(r & 32'h0000_00E8, {24'h0, mask & 8'hE8});
         c = 8'($urandom);
         v = '0;
         {v.overflow, v.match_a, v.match_b, v.force_a, v.force_b} = {c[7:5], c[1:0]};
         pulse(v, 1);
         ef = ef | (c & {1'b1, ~c[1], ~c[0], 5'h00});
         chk_all();
         c = 8'($urandom);
         apb(1'b1, tmirq_pkg::ADDR_FLAG_STATUS, {24'h0, c});
         ef = ef & ~c;
         chk_all();
      end
      $display("test random done");
      mask = 8'hFF;
      glb <= 1'b1;
      apb(1'b1, tmirq_pkg::ADDR_ENABLE_MASK, 32'h0000_00FF);
      clr_mode(tmirq_pkg::MODE_NORMAL);
      pin <= ~pin;
      // The edge strobe is held long enough to overlap the two-flop pin synchroniser.
      pulse(8'h04, 4);
      pulse(8'h98, 1);
      ef = 8'hE8;
      chk_all();
      m_en <= 1'b1;
      for (int n = 0; n < 100 && req != '0; n++) @(posedge clk);
      ef = 8'h00;
      chk_all();
      m_en <= 1'b0;
      $display("test ack done");
      clr_mode(tmirq_pkg::MODE_CTC_CAPT);
      pin <= ~pin;
      pulse(8'h04, 4);
      chk_all();
      pulse(8'h40, 1);
      pulse(8'h80, 1);
      ef = 8'h88;
      chk_all();
      clr_mode(tmirq_pkg::MODE_PFC_CAPT);
      pulse(8'h80, 1);
      chk_all();
      pulse(8'h20, 1);
      ef = 8'h80;
      chk_all();
      clr_mode(tmirq_pkg::MODE_FAST_CAPT);
      pulse(8'h40, 1);
      ef = 8'h88;
      chk_all();
      clr_mode(tmirq_pkg::MODE_CTC_CMPA);
      pulse(8'hC0, 1);
      ef = 8'h80;
      chk_all();
      $display("test modes done");
      stop_test();
   end
endmodule : tmirq_flags_test
`default_nettype wire
